// >>> core/pqc_pkg.sv
// shared constants and types of the pulse and quadrature counter
package pqc_pkg;
  // clock and timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam int DB_TIME_US  = 100;
  localparam int DB_CYC      = DB_TIME_US * CLK_MHZ;
  localparam int DB_W        = 12;
  localparam int CNT_W       = 32;
  localparam logic [47:0] MS_PER_S   = 48'h0000_0000_03E8;
  localparam logic [47:0] CLK_HZ_48  = 48'h0000_0131_2D00;
  localparam logic [31:0] CLK_MHZ_32 = 32'h0000_0014;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_SCAN_MS = 8'h08;
  localparam logic [7:0] REG_PER_CYC = 8'h0C;
  localparam logic [7:0] REG_PER_RES = 8'h10;
  localparam logic [7:0] REG_FMT     = 8'h14;
  localparam logic [7:0] REG_SWMODE  = 8'h18;
  localparam logic [7:0] REG_Q_NET   = 8'h1C;
  localparam logic [7:0] REG_Q_FWD   = 8'h20;
  localparam logic [7:0] REG_Q_REV   = 8'h24;
  localparam logic [7:0] REG_CH_BASE = 8'h40;
  // control field positions
  localparam int CTRL_PGO   = 0;
  localparam int CTRL_PSEL  = 1;
  localparam int CTRL_PHZ   = 3;
  localparam int CTRL_QEN   = 4;
  localparam int CTRL_QPAIR = 5;
  localparam int CTRL_QMODE = 6;
  localparam int CTRL_QCLR  = 8;
  // reset values
  localparam logic [31:0] SCAN_MS_RST = 32'h0000_03E8;
  localparam logic [15:0] PER_CYC_RST = 16'h000A;
  // result formats, quadrature modes and period timer and divider state encodings
  localparam logic [1:0] FMT_COUNT = 2'h0;
  localparam logic [1:0] FMT_HZ    = 2'h1;
  localparam logic [1:0] FMT_AVG   = 2'h2;
  typedef enum logic [1:0] {Q_X1 = 2'h0, Q_X2 = 2'h1, Q_X4 = 2'h2} qmode_t;
  typedef enum logic [2:0] {P_IDLE = 3'h1, P_ARM = 3'h2, P_RUN = 3'h4}
    per_state_t;
  typedef enum logic [2:0] {D_IDLE = 3'h1, D_RUN = 3'h2, D_DONE = 3'h4}
    div_state_t;
endpackage : pqc_pkg

// >>> core/quad_if.sv
// link between the counter top and its quadrature decoder
`timescale 1ns/1ps
interface quad_if;
  logic        en;
  logic        a;
  logic        b;
  logic [1:0]  mode;
  logic        clear;
  logic [31:0] net;
  logic [31:0] fwd;
  logic [31:0] rev;
  logic        dir;
  modport dec  (input en, a, b, mode, clear, output net, fwd, rev, dir);
  modport host (output en, a, b, mode, clear, input net, fwd, rev, dir);
endinterface : quad_if

// >>> core/quad_decoder.sv
// quadrature decoder with one, two and four counts per cycle
`timescale 1ns/1ps
module quad_decoder (
  input wire logic clk_in,
  input wire logic reset_n_in,
  quad_if.dec      q
);
  logic a_prev;
  logic b_prev;
  logic primed;

  // a valid step changes exactly one line; up means line a leads
  wire a_chg = q.a ^ a_prev;
  wire b_chg = q.b ^ b_prev;
  wire step  = primed & (a_chg ^ b_chg);
  wire up    = q.a ^ b_prev;
  wire x1    = a_chg & (up ? q.a : ~q.a);                      // RQ13
  wire hit   = (q.mode == pqc_pkg::Q_X4) ? step :              // RQ15
               (q.mode == pqc_pkg::Q_X2) ? (step & a_chg) :    // RQ14
               (step & x1);

  // first cycle after reset only loads the lines, no false step
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      primed <= 1'b0;
    end else begin
      a_prev <= q.a;
      b_prev <= q.b;
      primed <= 1'b1;
    end
  end

  // net count, per-direction counts and last direction
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q.net <= 32'h0;
      q.fwd <= 32'h0;
      q.rev <= 32'h0;
      q.dir <= 1'b0;
    end else if (q.clear) begin
      q.net <= 32'h0;
      q.fwd <= 32'h0;
      q.rev <= 32'h0;
    end else if (q.en && hit) begin
      q.net <= up ? q.net + 32'h1 : q.net - 32'h1;   // RQ11
      q.fwd <= up ? q.fwd + 32'h1 : q.fwd;           // RQ12
      q.rev <= up ? q.rev : q.rev + 32'h1;           // RQ12
      q.dir <= up;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_x4_forward: // RQ15
  assert property (q.en && !q.clear && q.mode == pqc_pkg::Q_X4 && step && up
                   |=> q.net == $past(q.net) + 32'h1 && q.dir)
    else $error("forward step in x4 mode not counted up");
  a_x1_quiet_b: // RQ13
  assert property (q.en && !q.clear && q.mode == pqc_pkg::Q_X1 && b_chg
                   |=> $stable(q.net))
    else $error("x1 mode counted an edge of line b");
  a_split_sum: // RQ12
  assert property (q.en && !q.clear && hit
                   |=> q.fwd + q.rev == $past(q.fwd) + $past(q.rev) + 32'h1)
    else $error("direction counts did not advance by one");
endmodule : quad_decoder

// >>> core/pulse_quadrature_counter.sv
// pulse accumulators, period timer, result formats and register port
`timescale 1ns/1ps
// Behaviour
// RQ1: each input has its own 32-bit accumulator
// RQ2: scan start captures count, then clears it
// RQ3: overflow past 2^32 counts simply wraps
// RQ4: accumulators count continuously, also between scans
// RQ5: period unit times edges with fast clock
// RQ6: period unit looks only during measurement
// RQ7: switch mode debounces, one count per closure
// RQ8: per channel count, hertz or average result
// RQ9: resolution one pulse per scan interval
// RQ10: two input pairs selectable as encoder pair
// RQ11: count up if a leads, down otherwise
// RQ12: report direction and per-direction counts
// RQ13: x1 mode counts rising a up, falling down
// RQ14: x2 mode counts both edges of a
// RQ15: x4 mode counts all edges of both
// RQ16: transition in either direction is detected
// RQ17: inputs pass two flip-flops before edge logic
// RQ18: hertz is count over interval, averaged
module pulse_quadrature_counter #(
  parameter int NCH      = 4,
  parameter int AVG_LOG2 = 2
) (
  input  wire logic           CLK_IN,
  input  wire logic           RESET_N_IN,
  input  wire logic           SCAN_TICK_IN,
  input  wire logic [NCH-1:0] SINGLE_ENDED_INPUTS_IN,
  input  wire logic [7:0]     ADDR_IN,
  input  wire logic [31:0]    WR_DATA_IN,
  input  wire logic           WR_STROBE_IN,
  input  wire logic           RD_STROBE_IN,
  output logic      [31:0]    RD_DATA_OUT
);
  localparam int CW    = pqc_pkg::CNT_W;
  localparam int SW    = CW + AVG_LOG2;
  localparam int DEPTH = 1 << AVG_LOG2;
  localparam int CH_W  = $clog2(NCH);

  generate
    if (NCH < 4 || NCH > 16) begin : g_bad_nch
      $error("NCH must lie between 4 and 16");
    end
    if (AVG_LOG2 < 1 || AVG_LOG2 > 4) begin : g_bad_avg
      $error("AVG_LOG2 must lie between 1 and 4");
    end
  endgenerate

  function automatic logic [1:0] fld2(input logic [31:0] v, input int i);
    return v[2*i +: 2];
  endfunction : fld2

  // configuration
  logic [31:0]    scan_ms;
  logic [15:0]    per_cyc;
  logic [31:0]    fmt;
  logic [NCH-1:0] sw_mode;
  logic [1:0]     per_sel;
  logic           per_hz;
  logic           q_en;
  logic           q_pair;
  logic [1:0]     q_mode;
  logic           per_go;
  logic           q_clr;

  wire wr_ctrl = WR_STROBE_IN && (ADDR_IN == pqc_pkg::REG_CTRL);
  wire wr_scan = WR_STROBE_IN && (ADDR_IN == pqc_pkg::REG_SCAN_MS);
  wire wr_pcyc = WR_STROBE_IN && (ADDR_IN == pqc_pkg::REG_PER_CYC);
  wire wr_fmt  = WR_STROBE_IN && (ADDR_IN == pqc_pkg::REG_FMT);
  wire wr_swm  = WR_STROBE_IN && (ADDR_IN == pqc_pkg::REG_SWMODE);

  // software-written settings; start and clear are one-cycle pulses
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      scan_ms <= pqc_pkg::SCAN_MS_RST;
      per_cyc <= pqc_pkg::PER_CYC_RST;
      fmt     <= 32'h0;
      sw_mode <= '0;
      per_sel <= 2'h0;
      per_hz  <= 1'b0;
      q_en    <= 1'b0;
      q_pair  <= 1'b0;
      q_mode  <= pqc_pkg::Q_X1;
      per_go  <= 1'b0;
      q_clr   <= 1'b0;
    end else begin
      per_go <= wr_ctrl & WR_DATA_IN[pqc_pkg::CTRL_PGO];
      q_clr  <= wr_ctrl & WR_DATA_IN[pqc_pkg::CTRL_QCLR];
      if (wr_ctrl) begin
        per_sel <= WR_DATA_IN[pqc_pkg::CTRL_PSEL +: 2];
        per_hz  <= WR_DATA_IN[pqc_pkg::CTRL_PHZ];
        q_en    <= WR_DATA_IN[pqc_pkg::CTRL_QEN];
        q_pair  <= WR_DATA_IN[pqc_pkg::CTRL_QPAIR];
        q_mode  <= WR_DATA_IN[pqc_pkg::CTRL_QMODE +: 2];
      end
      if (wr_scan) scan_ms <= WR_DATA_IN;
      if (wr_pcyc) per_cyc <= WR_DATA_IN[15:0];
      if (wr_fmt)  fmt     <= WR_DATA_IN;
      if (wr_swm)  sw_mode <= WR_DATA_IN[NCH-1:0];
    end
  end

  // input synchronisers and edge history
  logic [NCH-1:0] s1;
  logic [NCH-1:0] s2;
  logic [2:0]     live;
  logic [NCH-1:0] filt;
  logic [NCH-1:0] lvl_prev;
  logic [NCH-1:0] evt;
  logic [CW-1:0]  acc  [NCH];
  logic [CW-1:0]  capt [NCH];
  logic [CW-1:0]  freq [NCH];
  logic [SW-1:0]  sum  [NCH];
  logic [CW-1:0]  ch_view [NCH];

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s1       <= '0;
      s2       <= '0;
      lvl_prev <= '0;
      live     <= 3'h0;
    end else begin
      s1       <= SINGLE_ENDED_INPUTS_IN;   // RQ17
      s2       <= s1;                       // RQ17
      lvl_prev <= filt;
      live     <= {live[1:0], 1'b1};  // idle-high pin is no edge at reset
    end
  end

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [pqc_pkg::DB_W-1:0] db_cnt;
      logic                     db_lvl;
      // contact bounce shorter than the hold time never reaches the count
      always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          db_cnt <= '0;
          db_lvl <= 1'b0;
        end else if (s2[i] == db_lvl) begin
          db_cnt <= '0;
        end else if (db_cnt == pqc_pkg::DB_W'(pqc_pkg::DB_CYC - 1)) begin
          db_lvl <= s2[i];                                   // RQ7
          db_cnt <= '0;
        end else begin
          db_cnt <= db_cnt + 1'b1;
        end
      end
      // closure pulls low, so switch mode counts the falling swing
      assign filt[i] = sw_mode[i] ? db_lvl : s2[i];
      assign evt[i]  = live[2] &
                       (sw_mode[i] ? (lvl_prev[i] & ~filt[i])    // RQ16
                                   : (~lvl_prev[i] & filt[i]));  // RQ16
      // an edge in the scan cycle opens the new interval, never lost
      always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          acc[i]  <= '0;
          capt[i] <= '0;
        end else if (SCAN_TICK_IN) begin
          capt[i] <= acc[i];                                 // RQ2
          acc[i]  <= CW'(evt[i]);                            // RQ2
        end else begin
          acc[i]  <= acc[i] + CW'(evt[i]);  // RQ1 RQ3 RQ4 RQ9
        end
      end
      assign ch_view[i] =
        (fld2(fmt, i) == pqc_pkg::FMT_HZ)  ? freq[i] :           // RQ8
        (fld2(fmt, i) == pqc_pkg::FMT_AVG) ? CW'(sum[i] >> AVG_LOG2) :
        capt[i];                                                 // RQ8
    end
  endgenerate

  // period timer: ignores its input unless armed or running
  pqc_pkg::per_state_t per_state;
  logic [31:0] per_ticks;
  logic [15:0] per_edges;
  logic        sp_prev;
  wire         sp_lvl  = s2[per_sel];
  wire         per_edge = sp_lvl & ~sp_prev;
  wire         per_fin  = (per_state == pqc_pkg::P_RUN) && per_edge &&
                          (per_edges + 16'h1 >= per_cyc);

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      per_state <= pqc_pkg::P_IDLE;
      per_ticks <= 32'h0;
      per_edges <= 16'h0;
      sp_prev   <= 1'b0;
    end else begin
      sp_prev <= sp_lvl;
      case (per_state)
        pqc_pkg::P_IDLE: begin
          if (per_go) per_state <= pqc_pkg::P_ARM;
        end
        pqc_pkg::P_ARM: begin
          if (per_edge) begin                                // RQ6
            per_state <= pqc_pkg::P_RUN;
            per_ticks <= 32'h0;
            per_edges <= 16'h0;
          end
        end
        pqc_pkg::P_RUN: begin
          per_ticks <= per_ticks + 32'h1;                    // RQ5
          if (per_edge) per_edges <= per_edges + 16'h1;
          if (per_fin) per_state <= pqc_pkg::P_IDLE;
        end
        default: per_state <= pqc_pkg::P_IDLE;
      endcase
    end
  end

  // one shared serial divider serves the hertz results and the timer
  pqc_pkg::div_state_t div_state;
  logic [47:0]     dvd;
  logic [47:0]     quo;
  logic [31:0]     dvs;
  logic [31:0]     rem;
  logic [5:0]      step;
  logic            freq_pend;
  logic            per_pend;
  logic            job_per;
  logic [CH_W-1:0] job_ch;
  logic [CH_W-1:0] run_ch;

  wire [32:0] part = {rem, dvd[47]};
  wire        fits = part >= {1'b0, dvs};
  wire [32:0] diff = part - {1'b0, dvs};
  wire [31:0] q32  = (|quo[47:32]) ? 32'hFFFF_FFFF : quo[31:0];
  wire        last_ch = (job_ch == CH_W'(NCH - 1));
  wire [47:0] f_dvd = {16'h0, capt[job_ch]} * pqc_pkg::MS_PER_S; // RQ18
  wire [47:0] p_dvd = per_hz ? {32'h0, per_cyc} * pqc_pkg::CLK_HZ_48
                             : {16'h0, per_ticks};
  wire [31:0] p_dvs = per_hz ? per_ticks
                             : {16'h0, per_cyc} * pqc_pkg::CLK_MHZ_32;
  wire        done_f = (div_state == pqc_pkg::D_DONE) && !job_per;
  wire        done_p = (div_state == pqc_pkg::D_DONE) && job_per;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      div_state <= pqc_pkg::D_IDLE;
      dvd       <= 48'h0;
      quo       <= 48'h0;
      dvs       <= 32'h0;
      rem       <= 32'h0;
      step      <= 6'h0;
      job_per   <= 1'b0;
      run_ch    <= '0;
    end else begin
      case (div_state)
        pqc_pkg::D_IDLE: begin
          if (freq_pend || per_pend) begin
            job_per   <= !freq_pend;
            run_ch    <= job_ch;
            dvd       <= freq_pend ? f_dvd : p_dvd;
            dvs       <= freq_pend ? scan_ms : p_dvs;
            rem       <= 32'h0;
            step      <= 6'h0;
            div_state <= pqc_pkg::D_RUN;
          end
        end
        pqc_pkg::D_RUN: begin
          dvd  <= {dvd[46:0], 1'b0};
          rem  <= fits ? diff[31:0] : part[31:0];
          quo  <= {quo[46:0], fits};
          step <= step + 6'h1;
          if (step == 6'h2F) div_state <= pqc_pkg::D_DONE;
        end
        pqc_pkg::D_DONE: div_state <= pqc_pkg::D_IDLE;
        default: div_state <= pqc_pkg::D_IDLE;
      endcase
    end
  end

  // job bookkeeping; a new scan restarts the channel sweep
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      freq_pend <= 1'b0;
      per_pend  <= 1'b0;
      job_ch    <= '0;
    end else begin
      if (SCAN_TICK_IN) begin
        freq_pend <= 1'b1;
        job_ch    <= '0;
      end else if (done_f) begin
        freq_pend <= !last_ch;
        job_ch    <= last_ch ? '0 : job_ch + 1'b1;
      end
      if (per_fin) per_pend <= 1'b1;
      else if (done_p) per_pend <= 1'b0;
    end
  end

  // hertz results, running sums and timer result
  logic [CW-1:0]       hist [NCH][DEPTH];
  logic [AVG_LOG2-1:0] hp;
  logic [31:0]         per_res;
  logic                per_done;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int c = 0; c < NCH; c++) begin
        freq[c] <= '0;
        sum[c]  <= '0;
        for (int d = 0; d < DEPTH; d++) hist[c][d] <= '0;
      end
      hp       <= '0;
      per_res  <= 32'h0;
      per_done <= 1'b0;
    end else begin
      if (done_f) begin
        freq[run_ch]     <= q32;                             // RQ18
        hist[run_ch][hp] <= q32;
        sum[run_ch]      <= sum[run_ch] + SW'(q32) - SW'(hist[run_ch][hp]);
        if (run_ch == CH_W'(NCH - 1)) hp <= hp + 1'b1;
      end
      if (done_p) begin
        per_res  <= q32;                                     // RQ5
        per_done <= 1'b1;
      end else if (per_go) begin
        per_done <= 1'b0;
      end
    end
  end

  // encoder pair takes the first or second pair of inputs
  quad_if qi ();
  assign qi.en    = q_en;
  assign qi.a     = q_pair ? s2[2] : s2[0];                  // RQ10
  assign qi.b     = q_pair ? s2[3] : s2[1];                  // RQ10
  assign qi.mode  = q_mode;
  assign qi.clear = q_clr;

  quad_decoder u_quad (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .q          (qi.dec)
  );

  // read selection; unmapped offsets read zero
  wire [7:0] ch_off = ADDR_IN - pqc_pkg::REG_CH_BASE;
  wire       ch_hit = (ADDR_IN[7:6] == 2'h1) && (ADDR_IN[1:0] == 2'h0) &&
                      (32'(ch_off[5:2]) < NCH);
  wire [31:0] ctrl_view = {23'h0, 1'b0, q_mode, q_pair, q_en, per_hz,
                           per_sel, 1'b0};
  wire [31:0] stat_view = {27'h0, qi.dir, freq_pend | per_pend, per_done,
                           per_state != pqc_pkg::P_IDLE,
                           div_state != pqc_pkg::D_IDLE};
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    if (ADDR_IN == pqc_pkg::REG_CTRL) rd_mux = ctrl_view;
    else if (ADDR_IN == pqc_pkg::REG_STATUS) rd_mux = stat_view;
    else if (ADDR_IN == pqc_pkg::REG_SCAN_MS) rd_mux = scan_ms;
    else if (ADDR_IN == pqc_pkg::REG_PER_CYC) rd_mux = {16'h0, per_cyc};
    else if (ADDR_IN == pqc_pkg::REG_PER_RES) rd_mux = per_res;
    else if (ADDR_IN == pqc_pkg::REG_FMT) rd_mux = fmt;
    else if (ADDR_IN == pqc_pkg::REG_SWMODE) rd_mux = 32'(sw_mode);
    else if (ADDR_IN == pqc_pkg::REG_Q_NET) rd_mux = qi.net;
    else if (ADDR_IN == pqc_pkg::REG_Q_FWD) rd_mux = qi.fwd;
    else if (ADDR_IN == pqc_pkg::REG_Q_REV) rd_mux = qi.rev;
    else if (ch_hit) rd_mux = ch_view[CH_W'(ch_off[5:2])];
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) RD_DATA_OUT <= 32'h0;
    else RD_DATA_OUT <= RD_STROBE_IN ? rd_mux : 32'h0;
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_scan_capture: // RQ2
  assert property (SCAN_TICK_IN |=> capt[0] == $past(acc[0]) &&
                   acc[0] == CW'($past(evt[0])))
    else $error("scan did not capture and clear the accumulator");
  a_acc_step: // RQ1
  assert property (!SCAN_TICK_IN && evt[0] |=> acc[0] == $past(acc[0]) + 1)
    else $error("pulse not added to the accumulator");
  a_acc_idle: // RQ4
  assert property (!SCAN_TICK_IN && !evt[0] |=> $stable(acc[0]))
    else $error("accumulator moved without a pulse");
  a_sync_depth: // RQ17
  assert property (evt[0] && !sw_mode[0] && $stable(sw_mode[0])
                   |-> $past(SINGLE_ENDED_INPUTS_IN[0], 2) &&
                       !$past(SINGLE_ENDED_INPUTS_IN[0], 3))
    else $error("edge not two flops behind the pin");
  a_debounce_gap: // RQ7
  assert property (evt[3] && sw_mode[3] && $stable(sw_mode[3])
                   |=> (!evt[3] || !sw_mode[3])[*8])
    else $error("switch closure counted twice");
  a_period_asleep: // RQ6
  assert property (per_state == pqc_pkg::P_IDLE |=> $stable(per_ticks))
    else $error("period timer moved while idle");
  a_period_tick: // RQ5
  assert property (per_state == pqc_pkg::P_RUN
                   |=> per_ticks == $past(per_ticks) + 32'h1)
    else $error("period timer missed a clock");
  a_read_late: // RQ8
  assert property (RD_STROBE_IN |=> RD_DATA_OUT == $past(rd_mux))
    else $error("read data not presented one cycle later");
  a_divide_len: // RQ18
  assert property ($rose(div_state == pqc_pkg::D_RUN)
                   |-> ##48 div_state == pqc_pkg::D_DONE)
    else $error("divider did not finish in 48 cycles");
endmodule : pulse_quadrature_counter

// >>> tb/sensor_model.sv
// sensor and encoder model driving the counter input lines
`timescale 1ns/1ps
module sensor_model (
  input  wire logic       clk_in,
  output logic      [3:0] lines_out
);
  // switch line idles high through its pull-up, the others low
  initial lines_out = 4'h8;

  // hold one line at a level for n cycles
  task automatic level(input int ch, input logic v, input int n);
    @(posedge clk_in);
    lines_out[ch] <= v;
    repeat (n - 1) @(posedge clk_in);
  endtask : level

  // square pulses, rising first; half sets fast or slow sensors
  task automatic pulses(input int ch, input int n, input int half);
    repeat (n) begin
      level(ch, 1'b1, half);
      level(ch, 1'b0, half);
    end
  endtask : pulses

  // full encoder cycles on lines 0 (a) and 1 (b), one line per step
  task automatic quad(input logic fwd, input int n);
    logic [7:0] pat;
    pat = fwd ? 8'h78 : 8'hB4;
    repeat (n) begin
      for (int i = 3; i >= 0; i--) begin
        @(posedge clk_in);
        lines_out[1:0] <= pat[2*i+:2];
        // steps wider than the synchronizer, so none is lost
        repeat (5) @(posedge clk_in);
      end
    end
  endtask : quad
endmodule : sensor_model

// >>> tb/tb_pulse_quadrature_counter.sv
// self-checking bench for the pulse and quadrature counter
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  bad_count++; $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb_pulse_quadrature_counter;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tick = 1'b0;
  logic [3:0]  lines;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] k;
  logic [31:0] d;
  int          bad_count = 0;
  int          num_checks = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  pulse_quadrature_counter #(
    .NCH      (4),
    .AVG_LOG2 (2)
  ) i_dut (
    .CLK_IN                 (clk),
    .RESET_N_IN             (rst_n),
    .SCAN_TICK_IN           (tick),
    .SINGLE_ENDED_INPUTS_IN (lines),
    .ADDR_IN                (addr),
    .WR_DATA_IN             (wdata),
    .WR_STROBE_IN           (wr),
    .RD_STROBE_IN           (rd),
    .RD_DATA_OUT            (rdata)
  );

  sensor_model u_sens (
    .clk_in    (clk),
    .lines_out (lines)
  );

  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex,
                        input string nm);
    logic [31:0] v;
    rd_reg(a, v);
    `CHK(nm, ex, v)
  endtask : rd_chk

  // scan tick, then room for all channel and period divider jobs
  task automatic scan();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (400) @(posedge clk);
  endtask : scan

  // poll the sticky period done flag, bounded
  task automatic wait_done();
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 200 && v[2] !== 1'b1; i++) begin
      rd_reg(pqc_pkg::REG_STATUS, v);
    end
  endtask : wait_done

  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog, well beyond the roughly 9k cycles of the run
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(pqc_pkg::REG_SCAN_MS, 32'h0000_03E8, "scan_ms");
    rd_chk(pqc_pkg::REG_PER_CYC, 32'h0000_000A, "per_cyc");
    rd_chk(8'h80, 32'h0000_0000, "unmapped");
    // raw counts, fast and slow sensors, counted between scans
    scan();
    rd_chk(pqc_pkg::REG_CH_BASE + 8'h0C, 32'h0, "ch3 idle");
    u_sens.pulses(0, 5, 3);
    u_sens.pulses(1, 7, 2);
    scan();
    rd_chk(pqc_pkg::REG_CH_BASE, 32'h5, "ch0 count");
    rd_chk(pqc_pkg::REG_CH_BASE + 8'h04, 32'h7, "ch1 count");
    // hertz over a half-second interval
    wr_reg(pqc_pkg::REG_FMT, 32'h1);
    wr_reg(pqc_pkg::REG_SCAN_MS, 32'h0000_01F4);
    u_sens.pulses(0, 9, 2);
    scan();
    rd_chk(pqc_pkg::REG_CH_BASE, 32'h12, "ch0 hz");
    rd_chk(pqc_pkg::REG_CH_BASE + 8'h04, 32'h0, "ch1 clear");
    // four scans of 8 Hz fill the running average
    repeat (4) begin
      u_sens.pulses(0, 4, 2);
      scan();
    end
    wr_reg(pqc_pkg::REG_FMT, 32'h2);
    rd_chk(pqc_pkg::REG_CH_BASE, 32'h8, "ch0 avg");
    // bouncy closure on the switch line gives one count
    wr_reg(pqc_pkg::REG_SWMODE, 32'h8);
    scan();
    u_sens.pulses(3, 3, 5);
    u_sens.level(3, 1'b0, 2100);
    u_sens.level(3, 1'b1, 2100);
    scan();
    rd_chk(pqc_pkg::REG_CH_BASE + 8'h0C, 32'h1, "switch");
    // period of 40 cycles over 4 input cycles: 2 us, then 500 kHz
    wr_reg(pqc_pkg::REG_PER_CYC, 32'h4);
    wr_reg(pqc_pkg::REG_CTRL, 32'h5);
    u_sens.pulses(2, 8, 20);
    wait_done();
    rd_chk(pqc_pkg::REG_PER_RES, 32'h2, "period us");
    wr_reg(pqc_pkg::REG_CTRL, 32'hD);
    u_sens.pulses(2, 8, 20);
    wait_done();
    rd_chk(pqc_pkg::REG_PER_RES, 32'h0007_A120, "period hz");
    // every encoder mode: 3 cycles forward, 1 back
    for (int m = 0; m < 3; m++) begin
      wr_reg(pqc_pkg::REG_CTRL, {23'h0, 1'b1, 2'(m), 6'h10});
      u_sens.quad(1'b1, 3);
      u_sens.quad(1'b0, 1);
      repeat (5) @(posedge clk);
      k = 32'h1 << m;
      rd_chk(pqc_pkg::REG_Q_NET, k << 1, "q net");
      rd_chk(pqc_pkg::REG_Q_FWD, k + (k << 1), "q fwd");
      rd_chk(pqc_pkg::REG_Q_REV, k, "q rev");
      rd_reg(pqc_pkg::REG_STATUS, d);
      `CHK("q dir", 1'b0, d[4])
    end
    // second pair watches inputs 2 and 3; reverse on 0/1 must not count
    wr_reg(pqc_pkg::REG_CTRL, 32'h0000_0130);
    u_sens.quad(1'b0, 1);
    u_sens.level(3, 1'b0, 6);
    u_sens.level(2, 1'b1, 6);
    rd_chk(pqc_pkg::REG_Q_NET, 32'h1, "q pair");
    end_of_test();
  end
endmodule : tb_pulse_quadrature_counter
